/* dv/tsf_clock_supervisor_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module tsf_sva_chk (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] rdata,
	input wire logic [1:0] sys_src,
	input wire logic sys_clk_hold,
	input wire logic cpu_clk_en,
	input wire logic periph_clk_en,
	input wire logic [2:0] int_freq_sel,
	input wire logic osc_fail_irq
);
	logic [5:0] sh_reg;
	// Shadow of idle, frequency and select fields; hardware switches must never touch them
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sh_reg <= 6'h0c;
		end else if (wr_en && addr == 4'h0) begin
			sh_reg <= {wdata[7:4], wdata[1:0]};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Read data lives only in the slot after a read
	property p_rd_idle; !$past(rd_en) |-> rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
	property p_unmapped; rd_en && addr > 4'ha |=> rdata == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped index read not zero");
	property p_ctrl_fields; rd_en && addr == 4'h0 |=> {rdata[7:4], rdata[1:0]} == sh_reg; endproperty
	a_ctrl_fields: assert property (p_ctrl_fields) else $error("control fields changed");
	// Two cycles of slack allow for a registered copy of the field
	property p_freq_copy;
		$past(reset_n, 2) && !$past(wr_en) && !$past(wr_en, 2) |-> int_freq_sel == sh_reg[4:2];
	endproperty
	a_freq_copy: assert property (p_freq_copy) else $error("frequency select copy wrong");
	property p_irq_off; wr_en && addr == 4'h3 && !wdata[7] ##1 !(wr_en && addr == 4'h3) |=> !osc_fail_irq; endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");
	property p_sleep_gate; sys_src == 2'h3 [*2] |-> !cpu_clk_en && !periph_clk_en; endproperty
	a_sleep_gate: assert property (p_sleep_gate) else $error("clocks running with no source");
	property p_hold_bound; $rose(sys_clk_hold) |-> ##[1:16] !sys_clk_hold; endproperty
	a_hold_bound: assert property (p_hold_bound) else $error("switch hold too long");
	property p_status; rd_en && addr == 4'h0 && sys_src == 2'h0 && !sys_clk_hold |=> rdata[3]; endproperty
	a_status: assert property (p_status) else $error("status low on primary");
	c_switch: cover property ($rose(sys_clk_hold));
	c_irq: cover property ($rose(osc_fail_irq));
	c_sleep: cover property (sys_src == 2'h3 && !cpu_clk_en);
endmodule
bind tsf_clock_supervisor tsf_sva_chk u_chk (.clk, .reset_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .sys_src,
	.sys_clk_hold, .cpu_clk_en, .periph_clk_en, .int_freq_sel, .osc_fail_irq);
`default_nettype wire

/* dv/tsf_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk, reset_n, wr_en, rd_en, sleep_req, wake_req, secondary_ready, ext_clk, lfint_clk, ext_run;
	logic sys_clk_hold, cpu_clk_en, periph_clk_en, osc_fail_irq;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, g;
	logic [1:0] sys_src, div;
	logic [2:0] int_freq_sel;
	logic [27:0] rows [0:6];
	int errors, cmp_count, cyc, i;
	tsf_clock_supervisor dut (.clk, .reset_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .ext_clk, .lfint_clk,
		.sleep_req, .wake_req, .secondary_ready, .sys_src, .sys_clk_hold, .cpu_clk_en, .periph_clk_en,
		.int_freq_sel, .osc_fail_irq);
	// 25 MHz system clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Both oscillators at clk/4; a stopped primary sits low with no falling edge
	always @(posedge clk) begin
		div <= div + 2'h1;
		ext_clk <= ext_run & div[1];
		lfint_clk <= div[1];
	end
	// Hang guard, far beyond the longest start-up chain
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			errors = errors + 1;
			summarize();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	// Read data is taken in the one cycle it stands
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 g = rdata;
	endtask
	task automatic wait_src(input logic [1:0] s, input int n, input string m);
		for (int k = 0; k < n && sys_src !== s; k++) tick(1);
		chk({6'h0, sys_src}, {6'h0, s}, m);
	endtask
	task automatic summarize();
		$display("checks %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Main sequence: reset, register rows, two-speed start, fail-safe
	initial begin
		rows = '{{4'h0, 8'h50, 8'hf3, 8'h50}, {4'h3, 8'h7f, 8'hff, 8'h7f}, {4'h5, 8'ha5, 8'hff, 8'ha5},
			{4'h6, 8'h3c, 8'hff, 8'h3c}, {4'h2, 8'h5a, 8'hff, 8'h5a}, {4'h8, 8'h00, 8'h01, 8'h00},
			{4'hc, 8'hff, 8'hff, 8'h00}};
		{reset_n, wr_en, rd_en, sleep_req, wake_req, secondary_ready} = 6'h0;
		ext_run = 1'b1;
		div = 2'h0;
		addr = 4'h0;
		wdata = 8'h00;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		wait_src(2'h0, 3000, "primary after reset");
		rd(4'h0);
		chk(g & 8'hf3, 8'h30, "control reset value");
		rd(4'h7);
		chk(g, 8'h07, "fuse reset value");
		chk({5'h0, int_freq_sel}, 8'h03, "frequency select reset");
		$display("test reset done");
		for (i = 0; i < 7; i++) begin
			wr(rows[i][27:24], rows[i][23:16]);
			rd(rows[i][27:24]);
			chk(g & rows[i][15:8], rows[i][7:0], "register row");
		end
		$display("test registers done");
		// Crystal with both fuses; sleep then wake starts on the internal clock
		wr(4'h7, 8'hc1);
		@(posedge clk);
		sleep_req <= 1'b1;
		@(posedge clk);
		sleep_req <= 1'b0;
		tick(20);
		chk({6'h0, sys_src}, 8'h03, "no source in sleep");
		chk({7'h0, cpu_clk_en}, 8'h00, "cpu gated in sleep");
		@(posedge clk);
		wake_req <= 1'b1;
		repeat (2) @(posedge clk);
		wake_req <= 1'b0;
		wait_src(2'h2, 100, "internal during start");
		chk({5'h0, int_freq_sel}, 8'h05, "start frequency");
		tick(3700);
		chk({6'h0, sys_src}, 8'h02, "internal before count ends");
		rd(4'h0);
		chk({7'h0, g[3]}, 8'h00, "status low while internal");
		wait_src(2'h0, 800, "switch to crystal");
		rd(4'h0);
		chk({7'h0, g[3]}, 8'h01, "status high on crystal");
		$display("test two-speed done");
		// Primary stops: fail-safe takes over and never returns by itself
		wr(4'h3, 8'h80);
		ext_run <= 1'b0;
		tick(100);
		chk({6'h0, sys_src}, 8'h00, "no failure before a sample half-cycle");
		wait_src(2'h2, 400, "fail-safe internal");
		chk({7'h0, osc_fail_irq}, 8'h01, "fail interrupt");
		rd(4'h4);
		chk({7'h0, g[7]}, 8'h01, "fail flag set");
		@(posedge clk);
		ext_run <= 1'b1;
		tick(600);
		chk({6'h0, sys_src}, 8'h02, "no return to failed clock");
		wr(4'h3, 8'h00);
		tick(3);
		chk({7'h0, osc_fail_irq}, 8'h00, "interrupt masked");
		wr(4'h4, 8'h00);
		rd(4'h4);
		chk({7'h0, g[7]}, 8'h00, "flag cleared under fail-safe");
		wr(4'h0, 8'h52);
		wr(4'h0, 8'h50);
		tick(200);
		chk({6'h0, sys_src}, 8'h02, "internal while timer reruns");
		wait_src(2'h0, 5000, "back to primary");
		$display("test fail-safe done");
		// Secondary selected and left without touching the select high bit
		@(posedge clk);
		secondary_ready <= 1'b1;
		wr(4'h0, 8'h51);
		wait_src(2'h1, 50, "secondary selected");
		wr(4'h0, 8'h50);
		wait_src(2'h0, 50, "primary again");
		$display("test secondary done");
		summarize();
	end
endmodule
`default_nettype wire

/* rtl/tsf_clock_supervisor.v */
// Operation
// RULE1 - Two-speed start only with fuse set, select 00 and a crystal mode
// RULE2 - Two-speed start after power-on (after power-up timer) and after wake-up
// RULE3 - During start-up run from internal oscillator at selected frequency
// RULE4 - Start-up timer counts 1024 external clock cycles
// RULE5 - On timer expiry set timeout status then switch glitch-free to external
// RULE6 - Timeout status reads 0 on internal clock, 1 on external clock
// RULE7 - Fail monitor works only with its fuse, in all external modes
// RULE8 - Fail monitor inactive until start-up timer expires
// RULE9 - Sample clock is low-frequency internal oscillator divided by 64
// RULE10 - Detector latch set by external falling edge, cleared by sample rising edge
// RULE11 - Failure when a sample half-cycle passes with no primary low
// RULE12 - On failure switch to internal source and set fail flag
// RULE13 - Interrupt request only when fail flag and its enable are both set
// RULE14 - After failure stay internal, never return automatically
// RULE15 - Fail-safe internal source follows the internal frequency select field
// RULE16 - Reset or select-high toggle clears fail-safe and restarts start-up timer
// RULE17 - While restarted timer runs stay internal; on timeout clear and go external
// RULE18 - Fail flag may be cleared whether or not fail-safe is cleared
// RULE19 - External clock and RC modes skip the start-up timer
// RULE20 - Software should set two-speed fuse when monitoring a crystal mode
// RULE21 - Idle-on-sleep at bit 7 gates CPU clock; select field at bits 1:0
// RULE22 - Three sources: primary, secondary, internal; sleep uses none
// RULE23 - Switch: two old rises, hold low, two new rises, release on new fall
// RULE24 - Select 00 primary, 01 secondary, 10 internal block
// RULE25 - Automatic switches leave the software select field unchanged
// RULE26 - Start-up timer restarts its count from zero on every restart
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "tsf_regs.vh"
module tsf_clock_supervisor (
	input wire clk,
	input wire reset_n,
	input wire [3:0] addr,
	input wire [7:0] wdata,
	input wire wr_en,
	input wire rd_en,
	output reg [7:0] rdata,
	input wire ext_clk,
	input wire lfint_clk,
	input wire sleep_req,
	input wire wake_req,
	input wire secondary_ready,
	output reg [1:0] sys_src,
	output reg sys_clk_hold,
	output reg cpu_clk_en,
	output reg periph_clk_en,
	output reg [2:0] int_freq_sel,
	output reg osc_fail_irq
);
	// Clock sources driven on sys_src
	localparam SRC_PRIMARY = 2'h0;
	localparam SRC_SECONDARY = 2'h1;
	localparam SRC_INTERNAL = 2'h2;
	localparam SRC_NONE = 2'h3;
	// Switch sequencer states
	localparam SW_IDLE = 3'h0;
	localparam SW_OLD_RISE = 3'h1;
	localparam SW_OLD_FALL = 3'h2;
	localparam SW_NEW_RISE = 3'h3;
	localparam SW_NEW_FALL = 3'h4;

	reg [7:0] osc_control_reg;
	reg [7:0] osc_control_second_reg;
	reg [7:0] osc_tuning_reg;
	reg [7:0] irq_enable_2_reg;
	reg [7:0] irq_flag_2_reg;
	reg [7:0] irq_priority_2_reg;
	reg [7:0] core_irq_control_reg;
	reg [7:0] config_1_high_reg;
	reg [7:0] config_2_low_reg;
	reg [7:0] config_3_high_reg;
	reg startup_timeout_status_reg;
	reg fail_safe_reg;
	reg ost_run_reg;
	reg [10:0] ost_cnt_reg;
	reg powerup_timer_run_reg;
	reg [15:0] powerup_timer_cnt_reg;
	reg asleep_reg;
	reg ext_q_reg, lf_q_reg;
	// Counts low-frequency edges for one half-period of the sample clock
	reg [4:0] div_cnt_reg;
	reg sample_clk_reg, sample_q_reg;
	reg latch_reg;
	reg [2:0] sw_state_reg;
	reg [1:0] sw_edges_reg;
	reg [1:0] sw_target_reg;
	reg [1:0] cur_src_reg;

	wire [1:0] scs = osc_control_reg[`TSF_SCS_HI:`TSF_SCS_LO];
	wire [3:0] fosc = config_1_high_reg[3:0];
	wire two_speed_enable_fuse = config_1_high_reg[`TSF_TWO_SPEED_ENABLE_FUSE_BIT];
	wire clock_monitor_enable_fuse = config_1_high_reg[`TSF_CLOCK_MONITOR_ENABLE_FUSE_BIT];

	// Crystal modes need the start-up timer; EC and RC do not
	function is_crystal;
		input [3:0] f;
		begin
			is_crystal = (f == `TSF_FOSC_LP) || (f == `TSF_FOSC_XT) || (f == `TSF_FOSC_HS) ||
				(f == `TSF_FOSC_HS_ALT);
		end
	endfunction

	// Any mode driven from outside the chip, internal block excluded
	function is_external;
		input [3:0] f;
		begin
			is_external = (f != `TSF_FOSC_INT_A) && (f != `TSF_FOSC_INT_B);
		end
	endfunction

	wire crystal = is_crystal(fosc);
	wire two_speed = two_speed_enable_fuse && (scs == `TSF_SCS_PRIMARY) && crystal; // RULE1
	wire ext_fall = ext_q_reg && !ext_clk;
	wire ext_rise = !ext_q_reg && ext_clk;
	wire sample_rise = sample_clk_reg && !sample_q_reg;
	wire sample_fall = !sample_clk_reg && sample_q_reg;
	// Monitor rests while any start-up wait runs, so a slow crystal is never flagged
	wire monitor_on = clock_monitor_enable_fuse && is_external(fosc) && !ost_run_reg && !powerup_timer_run_reg && !asleep_reg; // RULE7 RULE8
	// Judged at the end of the high half: the latch was cleared at the rise, and a
	// primary falling edge in this very cycle still counts as alive
	wire fail_detect = monitor_on && sample_fall && !latch_reg && !ext_fall && !fail_safe_reg; // RULE11
	wire wr_ctl = wr_en && (addr == `TSF_ADDR_OSC_CONTROL);
	// Of control writes, only a change of the high select bit restarts the start-up timer; wake restarts it too
	wire source_select_high_bit_toggle = wr_ctl && (wdata[`TSF_SCS_HI] != osc_control_reg[`TSF_SCS_HI]);
	wire wake = asleep_reg && wake_req;
	// The last falling edge ends the count, so the counter itself stops one short
	wire ost_done = ost_run_reg && ext_fall && (ost_cnt_reg == `TSF_OST_COUNT - 11'h1);

	// Desired source: sleep without idle gives none, then fail-safe forces internal; start-up gives internal with two-speed, else none
	// A secondary source that is not yet running leaves the current source in place
	reg [1:0] want_src;
	always @* begin
		if (asleep_reg && !osc_control_reg[`TSF_IDLE_BIT])
			want_src = SRC_NONE; // RULE22
		else if (fail_safe_reg)
			want_src = SRC_INTERNAL; // RULE12 RULE14 RULE17
		else if (scs == `TSF_SCS_SECONDARY)
			want_src = secondary_ready ? SRC_SECONDARY : cur_src_reg; // RULE24
		else if (scs[1])
			want_src = SRC_INTERNAL; // RULE24
		else if (ost_run_reg || powerup_timer_run_reg)
			want_src = two_speed ? SRC_INTERNAL : SRC_NONE; // RULE3
		else
			want_src = SRC_PRIMARY; // RULE5
	end

	// Sampling of the outside clocks and the sample-clock divider
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ext_q_reg <= 1'b0;
			lf_q_reg <= 1'b0;
			div_cnt_reg <= 5'h0;
			sample_clk_reg <= 1'b0;
			sample_q_reg <= 1'b0;
			latch_reg <= 1'b0;
		end else begin
			ext_q_reg <= ext_clk;
			lf_q_reg <= lfint_clk;
			sample_q_reg <= sample_clk_reg;
			// Toggling every 32 edges gives a sample period of 64 low-frequency cycles
			if (lfint_clk && !lf_q_reg) begin
				div_cnt_reg <= div_cnt_reg + 5'h1;
				if (div_cnt_reg == `TSF_SAMPLE_DIV)
					sample_clk_reg <= !sample_clk_reg; // RULE9
			end
			// Set wins so an edge coinciding with the clear is kept
			if (ext_fall)
				latch_reg <= 1'b1; // RULE10
			else if (sample_rise)
				latch_reg <= 1'b0; // RULE10
		end
	end

	// Power-up timer, start-up timer, sleep state and fail-safe condition
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			powerup_timer_run_reg <= 1'b1;
			powerup_timer_cnt_reg <= 16'h0;
			ost_run_reg <= 1'b1;
			ost_cnt_reg <= 11'h0;
			startup_timeout_status_reg <= 1'b0;
			fail_safe_reg <= 1'b0; // RULE16
			asleep_reg <= 1'b0;
		end else begin
			// Power-up timer runs once after reset; with its fuse clear it ends at once
			if (powerup_timer_run_reg) begin
				if (!config_2_low_reg[`TSF_PWRTEN_BIT] || powerup_timer_cnt_reg == `TSF_POWERUP_TIMER_COUNT)
					powerup_timer_run_reg <= 1'b0; // RULE2
				else
					powerup_timer_cnt_reg <= powerup_timer_cnt_reg + 16'h1;
			end
			if (sleep_req && !asleep_reg) begin
				asleep_reg <= 1'b1;
				startup_timeout_status_reg <= 1'b0;
				ost_run_reg <= 1'b0;
			end else if (wake || source_select_high_bit_toggle) begin
				// Always restart; modes without a crystal drop out on the next edge
				asleep_reg <= 1'b0;
				ost_run_reg <= 1'b1; // RULE2 RULE16
				ost_cnt_reg <= 11'h0; // RULE26
				startup_timeout_status_reg <= 1'b0;
			end else if (ost_run_reg && !crystal) begin
				// No start-up wait: the external source is ready at once, and a
				// restart clears the fail-safe condition straight away
				ost_run_reg <= 1'b0; // RULE19
				startup_timeout_status_reg <= 1'b1; // RULE6
				fail_safe_reg <= 1'b0; // RULE16
			end else if (ost_done && !powerup_timer_run_reg) begin
				ost_run_reg <= 1'b0;
				startup_timeout_status_reg <= 1'b1; // RULE4 RULE5
				fail_safe_reg <= 1'b0; // RULE17
			end else if (ost_run_reg && ext_fall && !powerup_timer_run_reg && !ost_done) begin
				ost_cnt_reg <= ost_cnt_reg + 11'h1; // RULE4
			end
			if (fail_detect) begin
				fail_safe_reg <= 1'b1; // RULE12
				startup_timeout_status_reg <= 1'b0;
			end
		end
	end

	// Glitch-free switch: old rises, hold, new rises, release
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sw_state_reg <= SW_IDLE;
			sw_edges_reg <= 2'h0;
			sw_target_reg <= SRC_NONE;
			cur_src_reg <= SRC_NONE;
			sys_src <= SRC_NONE;
			sys_clk_hold <= 1'b0;
		end else begin
			case (sw_state_reg)
			// Leaving no source skips the old-clock phase: there is no old clock to wait for
			SW_IDLE: begin
				if (want_src != cur_src_reg) begin
					sw_target_reg <= want_src;
					sw_edges_reg <= 2'h0;
					sw_state_reg <= (cur_src_reg == SRC_NONE) ? SW_NEW_RISE : SW_OLD_RISE;
				end
			end
			SW_OLD_RISE: begin
				if (sw_edges_reg == `TSF_SWITCH_EDGES) begin
					sw_state_reg <= SW_OLD_FALL; // RULE23
					sw_edges_reg <= 2'h0;
				end else
					sw_edges_reg <= sw_edges_reg + 2'h1;
			end
			SW_OLD_FALL: begin
				sys_clk_hold <= 1'b1; // RULE23
				sw_state_reg <= SW_NEW_RISE;
			end
			SW_NEW_RISE: begin
				if (sw_edges_reg == `TSF_SWITCH_EDGES)
					sw_state_reg <= SW_NEW_FALL; // RULE23
				else
					sw_edges_reg <= sw_edges_reg + 2'h1;
			end
			SW_NEW_FALL: begin
				// Only now does the new source reach the system
				sys_clk_hold <= 1'b0;
				cur_src_reg <= sw_target_reg;
				sys_src <= sw_target_reg;
				sw_state_reg <= SW_IDLE;
			end
			default: sw_state_reg <= SW_IDLE;
			endcase
		end
	end

	// Register writes; automatic switches never touch the select field
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			osc_control_reg <= `TSF_OSC_CONTROL_RST;
			osc_control_second_reg <= 8'h00;
			osc_tuning_reg <= 8'h00;
			irq_enable_2_reg <= 8'h00;
			irq_flag_2_reg <= 8'h00;
			irq_priority_2_reg <= 8'h00;
			core_irq_control_reg <= 8'h00;
			config_1_high_reg <= `TSF_CONFIG_1_HIGH_RST;
			config_2_low_reg <= 8'h00;
			config_3_high_reg <= 8'h00;
		end else begin
			if (wr_ctl)
				osc_control_reg <= {wdata[7:4], 1'b0, wdata[2:0]}; // RULE21 RULE25
			if (wr_en && addr == `TSF_ADDR_OSC_CONTROL_SECOND)
				osc_control_second_reg <= wdata;
			if (wr_en && addr == `TSF_ADDR_OSC_TUNING)
				osc_tuning_reg <= wdata;
			if (wr_en && addr == `TSF_ADDR_IRQ_ENABLE_2)
				irq_enable_2_reg <= wdata;
			if (wr_en && addr == `TSF_ADDR_IRQ_PRIORITY_2)
				irq_priority_2_reg <= wdata;
			if (wr_en && addr == `TSF_ADDR_CORE_IRQ_CONTROL)
				core_irq_control_reg <= wdata;
			if (wr_en && addr == `TSF_ADDR_CONFIG_1_HIGH)
				config_1_high_reg <= wdata;
			if (wr_en && addr == `TSF_ADDR_CONFIG_2_LOW)
				config_2_low_reg <= wdata;
			if (wr_en && addr == `TSF_ADDR_CONFIG_3_HIGH)
				config_3_high_reg <= wdata;
			// Flag clear is independent of fail-safe; a new failure wins
			if (wr_en && addr == `TSF_ADDR_IRQ_FLAG_2)
				irq_flag_2_reg <= wdata; // RULE18
			if (fail_detect)
				irq_flag_2_reg[`TSF_FAIL_BIT] <= 1'b1; // RULE12
		end
	end

	// Outputs and read data, all registered
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= 8'h00;
			cpu_clk_en <= 1'b0;
			periph_clk_en <= 1'b0;
			int_freq_sel <= 3'h0;
			osc_fail_irq <= 1'b0;
		end else begin
			cpu_clk_en <= !asleep_reg && sys_src != SRC_NONE; // RULE21
			periph_clk_en <= (!asleep_reg || osc_control_reg[`TSF_IDLE_BIT]) && sys_src != SRC_NONE;
			int_freq_sel <= osc_control_reg[`TSF_IRCF_HI:`TSF_IRCF_LO]; // RULE3 RULE15
			// Level request: drops as soon as either the flag or the enable is cleared
			osc_fail_irq <= irq_flag_2_reg[`TSF_FAIL_BIT] && irq_enable_2_reg[`TSF_FAIL_BIT]; // RULE13
			// Read data stands for one cycle only
			rdata <= 8'h00;
			if (rd_en) begin
				case (addr)
				`TSF_ADDR_OSC_CONTROL: rdata <= {osc_control_reg[7:4], startup_timeout_status_reg, osc_control_reg[2:0]}; // RULE6
				`TSF_ADDR_OSC_CONTROL_SECOND: rdata <= osc_control_second_reg;
				`TSF_ADDR_OSC_TUNING: rdata <= osc_tuning_reg;
				`TSF_ADDR_IRQ_ENABLE_2: rdata <= irq_enable_2_reg;
				`TSF_ADDR_IRQ_FLAG_2: rdata <= irq_flag_2_reg;
				`TSF_ADDR_IRQ_PRIORITY_2: rdata <= irq_priority_2_reg;
				`TSF_ADDR_CORE_IRQ_CONTROL: rdata <= core_irq_control_reg;
				`TSF_ADDR_CONFIG_1_HIGH: rdata <= config_1_high_reg;
				`TSF_ADDR_CONFIG_2_LOW: rdata <= config_2_low_reg;
				`TSF_ADDR_CONFIG_3_HIGH: rdata <= config_3_high_reg;
				`TSF_ADDR_EVENTS: rdata <= {5'h0, fail_safe_reg, asleep_reg, ost_run_reg};
				default: rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* rtl/tsf_regs.vh */
`ifndef TSF_REGS_VH
`define TSF_REGS_VH
// Register indices on the plain port
`define TSF_ADDR_OSC_CONTROL 4'h0
`define TSF_ADDR_OSC_CONTROL_SECOND 4'h1
`define TSF_ADDR_OSC_TUNING 4'h2
`define TSF_ADDR_IRQ_ENABLE_2 4'h3
`define TSF_ADDR_IRQ_FLAG_2 4'h4
`define TSF_ADDR_IRQ_PRIORITY_2 4'h5
`define TSF_ADDR_CORE_IRQ_CONTROL 4'h6
`define TSF_ADDR_CONFIG_1_HIGH 4'h7
`define TSF_ADDR_CONFIG_2_LOW 4'h8
`define TSF_ADDR_CONFIG_3_HIGH 4'h9
`define TSF_ADDR_EVENTS 4'ha
// Field positions
`define TSF_IDLE_BIT 7
`define TSF_IRCF_HI 6
`define TSF_IRCF_LO 4
`define TSF_STARTUP_TIMEOUT_STATUS_BIT 3
`define TSF_SCS_HI 1
`define TSF_SCS_LO 0
`define TSF_FAIL_BIT 7
`define TSF_TWO_SPEED_ENABLE_FUSE_BIT 7
`define TSF_CLOCK_MONITOR_ENABLE_FUSE_BIT 6
`define TSF_PWRTEN_BIT 0
`define TSF_EV_POR_BIT 0
`define TSF_EV_WAKE_BIT 1
`define TSF_EV_SLEEP_BIT 2
// Clock source select codes
`define TSF_SCS_PRIMARY 2'h0
`define TSF_SCS_SECONDARY 2'h1
`define TSF_SCS_INTERNAL 2'h2
// Primary oscillator configuration codes
`define TSF_FOSC_LP 4'h0
`define TSF_FOSC_XT 4'h1
`define TSF_FOSC_HS 4'h2
`define TSF_FOSC_HS_ALT 4'h3
`define TSF_FOSC_RC 4'h7
`define TSF_FOSC_RESISTOR_CAP_IO_MODE 4'h6
`define TSF_FOSC_EC_LO 4'h4
`define TSF_FOSC_INT_A 4'h8
`define TSF_FOSC_INT_B 4'h9
// Timing counts
`define TSF_OST_COUNT 11'h400
`define TSF_SAMPLE_DIV 5'h1f
`define TSF_POWERUP_TIMER_COUNT 16'h0400
`define TSF_SWITCH_EDGES 2'h2
// Reset values
`define TSF_OSC_CONTROL_RST 8'h30
`define TSF_CONFIG_1_HIGH_RST 8'h07
`endif
